// *** design/multi_frame_rx_defs.vh ***
`ifndef MULTI_FRAME_RX_DEFS_VH
`define MULTI_FRAME_RX_DEFS_VH

// Register map, byte addresses on the 9-bit register port
`define MFR_REG_CTRL 9'h000
`define MFR_REG_EVENT 9'h004
`define MFR_REG_RXSTAT 9'h008
`define MFR_BUF_BASE 9'h100
`define MFR_BUF_SEL_BIT 8

// Transceive control fields
`define MFR_CTRL_EN_BIT 0
`define MFR_CTRL_IDLE_BIT 2
`define MFR_CTRL_RESET 1'b0

// Event status fields, write one to clear
`define MFR_EVT_RX_BIT 0
`define MFR_EVT_END_BIT 1

// Receive status fields
`define MFR_RXS_CNT_LSB 0
`define MFR_RXS_BUSY_BIT 4

// Per-frame status word layout
`define MFR_SW_CNT_LSB 0
`define MFR_SW_CNT_W 8
`define MFR_SW_ANY_BIT 8
`define MFR_SW_CRC_BIT 9
`define MFR_SW_SHORT_BIT 10
`define MFR_SW_COLL_BIT 11
`define MFR_SW_LEN_BIT 12

// Buffer partitioning
`define MFR_MAX_FRAMES 8
`define MFR_SUB_BYTES 32
`define MFR_MAX_PAYLOAD 28

// Receiver gap timing
`define MFR_CLK_FREQ_KHZ 200000
`define MFR_RF_FREQ_KHZ 13560
`define MFR_GAP_RF_CYCLES 2
`define MFR_GAP_MAX_NS 2000
`define MFR_GAP_CLKS ((`MFR_GAP_RF_CYCLES * `MFR_CLK_FREQ_KHZ + \
    `MFR_RF_FREQ_KHZ - 1) / `MFR_RF_FREQ_KHZ)
`define MFR_GAP_MAX_CLKS (`MFR_GAP_MAX_NS * (`MFR_CLK_FREQ_KHZ / 1000) \
    / 1000)

`endif

// *** design/mfr_sub_buffer.v ***
`timescale 1ns/1ps
`default_nettype none

module mfr_sub_buffer #(
    parameter DEPTH = 64,
    parameter AW = 6
) (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_we,
    input wire [AW-1:0] i_waddr,
    input wire [31:0] i_wdata,
    input wire [3:0] i_be,
    input wire i_rd,
    input wire [AW-1:0] i_raddr,
    input wire i_alt_sel,
    input wire [31:0] i_alt_data,
    output reg [31:0] o_q
);

wire [31:0] rd_word;

////////////////////////////////////////////////////////////////
// One array per byte lane keeps each lane single-driven
genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : lane
        reg [7:0] mem [0:DEPTH-1];
        always @(posedge i_clk) begin
            if (i_we && i_be[g]) begin
                mem[i_waddr] <= i_wdata[8*g+7:8*g];
            end
        end
        assign rd_word[8*g+7:8*g] = mem[i_raddr];
    end
endgenerate

////////////////////////////////////////////////////////////////
// Register data share this flop so the read port stays registered
always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_q <= 32'h0000_0000;
    end else if (i_rd) begin
        o_q <= i_alt_sel ? i_alt_data : rd_word;
    end else begin
        o_q <= 32'h0000_0000;
    end
end

endmodule

`default_nettype wire

// *** design/mfr_gap_timer.v ***
`timescale 1ns/1ps
`default_nettype none

module mfr_gap_timer #(
    parameter CYCLES = 30
) (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_start,
    output reg o_done
);

reg [15:0] cnt_q;
reg run_q;

always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        cnt_q <= 16'h0000;
        run_q <= 1'b0;
        o_done <= 1'b0;
    end else begin
        o_done <= 1'b0;
        if (i_start) begin
            cnt_q <= 16'h0001;
            run_q <= 1'b1;
        end else if (run_q) begin
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q >= CYCLES[15:0] - 16'h0001) begin
                run_q <= 1'b0;
                o_done <= 1'b1;
            end
        end
    end
end

endmodule

`default_nettype wire

// *** design/multi_frame_rx_buffer.v ***
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "multi_frame_rx_defs.vh"

module multi_frame_rx_buffer #(
    parameter MAX_FRAMES = `MFR_MAX_FRAMES,
    parameter SUB_BYTES = `MFR_SUB_BYTES,
    parameter MAX_PAYLOAD = `MFR_MAX_PAYLOAD,
    parameter GAP_CLKS = `MFR_GAP_CLKS
) (
    input wire I_SYS_CLK,
    input wire I_RST_B,
    input wire [8:0] I_ADDR,
    input wire [31:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output wire [31:0] O_RDATA,
    input wire I_CYCLE_START,
    input wire I_RX_SOF,
    input wire I_RX_VALID,
    input wire [7:0] I_RX_DATA,
    input wire I_RX_EOF,
    input wire I_CRC_OK,
    input wire I_COLLISION,
    output reg O_RX_ENABLE,
    output reg O_FRAME_DONE,
    output reg O_AWAIT_SEND,
    output reg O_BUSY
);

localparam FW = $clog2(MAX_FRAMES);
localparam BW = $clog2(SUB_BYTES);
localparam WAW = FW + BW - 2;
localparam DEPTH = MAX_FRAMES * SUB_BYTES / 4;

localparam [1:0] ST_IDLE = 2'd0;
localparam [1:0] ST_RECV = 2'd1;
localparam [1:0] ST_STAT = 2'd2;
localparam [1:0] ST_GAP = 2'd3;

localparam [7:0] PAYLOAD_MAX = MAX_PAYLOAD;
localparam [FW:0] FRAMES_MAX = MAX_FRAMES;

reg [1:0] state_q;
reg en_q;
reg [FW:0] frames_q;
reg in_frame_q;
reg [7:0] cnt_q;
reg [7:0] len_q;
reg len_big_q;
reg [31:0] status_q;
reg evt_rx_q;
reg evt_end_q;
reg gap_start_q;

wire gap_done;
wire wr_ctrl = I_WR && (I_ADDR == `MFR_REG_CTRL);
wire wr_evt = I_WR && (I_ADDR == `MFR_REG_EVENT);
wire idle_cmd = wr_ctrl && I_WDATA[`MFR_CTRL_IDLE_BIT];

////////////////////////////////////////////////////////////////
// Frame byte capture and status word build
wire byte_in = (state_q == ST_RECV) && in_frame_q && I_RX_VALID;
wire first_big = (cnt_q == 8'h00) && (I_RX_DATA > PAYLOAD_MAX);
// Nothing is copied once the length byte is seen to be too large
wire store_ok = (cnt_q < PAYLOAD_MAX) && !first_big && !len_big_q;
wire byte_we = byte_in && store_ok && !idle_cmd;
wire frame_end = (state_q == ST_RECV) && in_frame_q && I_RX_EOF;

wire short_f = (cnt_q < len_q);
wire len_f = len_big_q || short_f;
wire crc_f = !I_CRC_OK;
wire any_f = crc_f || short_f || I_COLLISION;

reg [31:0] status_d;
always @* begin
    status_d = 32'h0000_0000;
    status_d[`MFR_SW_CNT_LSB +: `MFR_SW_CNT_W] = cnt_q;
    status_d[`MFR_SW_ANY_BIT] = any_f;
    status_d[`MFR_SW_CRC_BIT] = crc_f;
    status_d[`MFR_SW_SHORT_BIT] = short_f;
    status_d[`MFR_SW_COLL_BIT] = I_COLLISION;
    status_d[`MFR_SW_LEN_BIT] = len_f;
end

////////////////////////////////////////////////////////////////
// Buffer write port: one byte lane per data byte, full word for status
wire [FW-1:0] frame_idx = frames_q[FW-1:0];
wire [BW-1:0] byte_idx = cnt_q[BW-1:0];
wire stat_we = (state_q == ST_STAT);
wire mem_we = byte_we || stat_we;
// Sub-buffer base is 32 times the frames already captured
wire [WAW-1:0] mem_waddr = stat_we ?
    {frame_idx, {(BW-2){1'b1}}} :
    {frame_idx, byte_idx[BW-1:2]};
wire [31:0] mem_wdata = stat_we ? status_q : {4{I_RX_DATA}};
wire [3:0] mem_be = stat_we ? 4'hf :
    (4'h1 << byte_idx[1:0]);

////////////////////////////////////////////////////////////////
// Register read data
reg [31:0] reg_rdata;
always @* begin
    reg_rdata = 32'h0000_0000;
    case (I_ADDR)
        `MFR_REG_CTRL: begin
            reg_rdata[`MFR_CTRL_EN_BIT] = en_q;
        end
        `MFR_REG_EVENT: begin
            reg_rdata[`MFR_EVT_RX_BIT] = evt_rx_q;
            reg_rdata[`MFR_EVT_END_BIT] = evt_end_q;
        end
        `MFR_REG_RXSTAT: begin
            reg_rdata[`MFR_RXS_CNT_LSB +: FW+1] = frames_q;
            reg_rdata[`MFR_RXS_BUSY_BIT] = O_BUSY;
        end
        default: begin
            reg_rdata = 32'h0000_0000;
        end
    endcase
end

wire buf_sel = I_ADDR[`MFR_BUF_SEL_BIT];

mfr_sub_buffer #(
    .DEPTH(DEPTH),
    .AW(WAW)
) u_buf (
    .i_clk(I_SYS_CLK),
    .i_rst_b(I_RST_B),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_be(mem_be),
    .i_rd(I_RD),
    .i_raddr(I_ADDR[WAW+1:2]),
    .i_alt_sel(!buf_sel),
    .i_alt_data(reg_rdata),
    .o_q(O_RDATA)
);

// Gap is counted from gap_start_q, which rises one cycle after the receiver drops
mfr_gap_timer #(
    .CYCLES(GAP_CLKS)
) u_gap (
    .i_clk(I_SYS_CLK),
    .i_rst_b(I_RST_B),
    .i_start(gap_start_q),
    .o_done(gap_done)
);

////////////////////////////////////////////////////////////////
// Control register and sticky events
always @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
        en_q <= `MFR_CTRL_RESET;
        evt_rx_q <= 1'b0;
        evt_end_q <= 1'b0;
    end else begin
        if (wr_ctrl) begin
            en_q <= I_WDATA[`MFR_CTRL_EN_BIT];
        end
        // Hardware set wins over a same-cycle clear
        if (stat_we) begin
            evt_rx_q <= 1'b1;
        end else if (wr_evt && I_WDATA[`MFR_EVT_RX_BIT]) begin
            evt_rx_q <= 1'b0;
        end
        if (stat_we && (frames_q + 1'b1 == FRAMES_MAX)) begin
            evt_end_q <= 1'b1;
        end else if (wr_evt && I_WDATA[`MFR_EVT_END_BIT]) begin
            evt_end_q <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////
// Multi-frame sequencer
always @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
        state_q <= ST_IDLE;
        frames_q <= {(FW+1){1'b0}};
        in_frame_q <= 1'b0;
        cnt_q <= 8'h00;
        len_q <= 8'h00;
        len_big_q <= 1'b0;
        status_q <= 32'h0000_0000;
        gap_start_q <= 1'b0;
        O_RX_ENABLE <= 1'b0;
        O_FRAME_DONE <= 1'b0;
        O_AWAIT_SEND <= 1'b0;
        O_BUSY <= 1'b0;
    end else begin
        O_FRAME_DONE <= 1'b0;
        O_AWAIT_SEND <= 1'b0;
        gap_start_q <= 1'b0;
        if (idle_cmd) begin
            // Abandoned cycle keeps frames already captured
            state_q <= ST_IDLE;
            in_frame_q <= 1'b0;
            O_RX_ENABLE <= 1'b0;
            O_BUSY <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (I_CYCLE_START && en_q) begin
                        frames_q <= {(FW+1){1'b0}};
                        state_q <= ST_RECV;
                        O_RX_ENABLE <= 1'b1;
                        O_BUSY <= 1'b1;
                    end
                end
                ST_RECV: begin
                    if (I_RX_SOF) begin
                        in_frame_q <= 1'b1;
                        cnt_q <= 8'h00;
                        len_q <= 8'h00;
                        len_big_q <= 1'b0;
                    end else if (frame_end) begin
                        status_q <= status_d;
                        in_frame_q <= 1'b0;
                        O_RX_ENABLE <= 1'b0;
                        state_q <= ST_STAT;
                    end else if (byte_in) begin
                        if (cnt_q == 8'h00) begin
                            len_q <= I_RX_DATA;
                            len_big_q <= first_big;
                        end
                        if (cnt_q != 8'hff) begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                end
                ST_STAT: begin
                    frames_q <= frames_q + 1'b1;
                    O_FRAME_DONE <= 1'b1;
                    if (frames_q + 1'b1 == FRAMES_MAX) begin
                        state_q <= ST_IDLE;
                        O_AWAIT_SEND <= 1'b1;
                        O_BUSY <= 1'b0;
                    end else begin
                        state_q <= ST_GAP;
                        gap_start_q <= 1'b1;
                    end
                end
                ST_GAP: begin
                    if (gap_done) begin
                        state_q <= ST_RECV;
                        O_RX_ENABLE <= 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
end

endmodule

`default_nettype wire

// *** testbench/mfr_card_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mfr_card_model (
    input wire logic i_clk,
    input wire logic i_rx_enable,
    output logic o_sof,
    output logic o_valid,
    output logic [7:0] o_data,
    output logic o_eof,
    output logic o_crc_ok,
    output logic o_coll
);
    initial begin
        o_sof = 1'b0;
        o_valid = 1'b0;
        o_data = 8'h5a;
        o_eof = 1'b0;
        o_crc_ok = 1'b0;
        o_coll = 1'b0;
    end
    function automatic logic [7:0] bv(input logic [2:0] f,
        input logic [7:0] i, input logic [7:0] len);
        bv = (i == 8'h00) ? len : {f, i[4:0]};
    endfunction
    // A card only answers while the reader listens
    task automatic send(input logic [2:0] f, input logic [7:0] len, n,
        input logic crc, col, output logic ok);
        int i;
        ok = 1'b0;
        for (i = 0; i < 400 && !ok; i++) begin
            @(posedge i_clk);
            ok = i_rx_enable;
        end
        if (ok) begin
            o_sof <= 1'b1;
            @(posedge i_clk);
            o_sof <= 1'b0;
            for (i = 0; i < n; i++) begin
                o_valid <= 1'b1;
                o_data <= bv(f, 8'(i), len);
                @(posedge i_clk);
            end
            o_valid <= 1'b0;
            o_data <= ~o_data;
            o_eof <= 1'b1;
            o_crc_ok <= crc;
            o_coll <= col;
            @(posedge i_clk);
            // Released lines flip so stale values never look valid
            o_eof <= 1'b0;
            o_crc_ok <= ~crc;
            o_coll <= ~col;
        end
    endtask
endmodule
`default_nettype wire

// *** testbench/mfr_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "multi_frame_rx_defs.vh"
module mfr_monitor #(
    parameter GAP_CLKS = 30
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    input wire logic [8:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [31:0] O_RDATA,
    input wire logic I_CYCLE_START,
    input wire logic O_RX_ENABLE,
    input wire logic O_FRAME_DONE,
    input wire logic O_AWAIT_SEND,
    input wire logic O_BUSY
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_B);
    // Receiver-off cycles inside a running cycle
    logic [7:0] gap_q;
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B)
            gap_q <= 8'h00;
        else if (!O_BUSY || O_RX_ENABLE)
            gap_q <= 8'h00;
        else
            gap_q <= gap_q + 8'h01;
    end
    start_gate_a: assert property ($rose(O_BUSY) |-> $past(I_CYCLE_START))
        else $error("busy rose without a start");
    arm_busy_a: assert property (O_RX_ENABLE |-> O_BUSY)
        else $error("receiver armed outside a cycle");
    rearm_a: assert property (O_FRAME_DONE && O_BUSY |->
        ##[1:400] (O_RX_ENABLE || !O_BUSY))
        else $error("receiver not re-armed");
    gap_min_a: assert property ($rose(O_RX_ENABLE) && gap_q != 0 |->
        gap_q >= GAP_CLKS)
        else $error("receiver gap too short");
    done_order_a: assert property (O_FRAME_DONE |->
        !$past(O_RX_ENABLE) && $past(O_RX_ENABLE, 2))
        else $error("frame done not after receiver stop");
    done_pulse_a: assert property (O_FRAME_DONE |=> !O_FRAME_DONE)
        else $error("frame done longer than one cycle");
    send_end_a: assert property (O_AWAIT_SEND |=>
        !O_BUSY && !O_AWAIT_SEND && !O_RX_ENABLE)
        else $error("cycle kept running after await send");
    idle_stop_a: assert property (I_WR && I_ADDR == `MFR_REG_CTRL &&
        I_WDATA[`MFR_CTRL_IDLE_BIT] |=> !O_RX_ENABLE && !O_BUSY)
        else $error("idle did not stop reception");
    count_max_a: assert property (I_RD && I_ADDR == `MFR_REG_RXSTAT |=>
        O_RDATA[3:0] <= 4'h8)
        else $error("frame count above eight");
    cover property (O_FRAME_DONE);
    cover property (O_AWAIT_SEND);
    cover property ($rose(O_RX_ENABLE) && gap_q != 0);
endmodule
bind multi_frame_rx_buffer mfr_monitor #(.GAP_CLKS(GAP_CLKS)) u_mon (
    .I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_CYCLE_START(I_CYCLE_START), .O_RX_ENABLE(O_RX_ENABLE),
    .O_FRAME_DONE(O_FRAME_DONE), .O_AWAIT_SEND(O_AWAIT_SEND),
    .O_BUSY(O_BUSY));
`default_nettype wire

// *** testbench/test_multi_frame_rx_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_multi_frame_rx_buffer;
    logic clk, rst_b, wr, rd, start, sof, valid, eof, crc_ok, coll;
    logic rx_en, done, send, busy;
    logic [8:0] addr;
    logic [31:0] wdata, rdata;
    logic [7:0] data;
    int failures = 0, num_checks = 0, dones = 0, sends = 0;
    // Frame table: length byte, bytes sent, crc good, collision
    logic [17:0] ft [8] = '{18'h01012, 18'h01414, 18'h0787a, 18'h02016,
        18'h01013, 18'h07072, 18'h01012, 18'h01819};
    multi_frame_rx_buffer u_dut (.I_SYS_CLK(clk), .I_RST_B(rst_b),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .I_CYCLE_START(start), .I_RX_SOF(sof),
        .I_RX_VALID(valid), .I_RX_DATA(data), .I_RX_EOF(eof),
        .I_CRC_OK(crc_ok), .I_COLLISION(coll), .O_RX_ENABLE(rx_en),
        .O_FRAME_DONE(done), .O_AWAIT_SEND(send), .O_BUSY(busy));
    mfr_card_model u_card (.i_clk(clk), .i_rx_enable(rx_en), .o_sof(sof),
        .o_valid(valid), .o_data(data), .o_eof(eof), .o_crc_ok(crc_ok),
        .o_coll(coll));
    always @(posedge clk) begin
        dones <= dones + int'(done);
        sends <= sends + int'(send);
    end
    ////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string nm);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [8:0] a, input logic [31:0] e,
        input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        // Read data stand one cycle only, so look mid-cycle
        @(negedge clk);
        chk(rdata, e, nm);
    endtask
    task automatic kick;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask
    // A hung frame ends the run instead of stalling it
    task automatic wait_dones(input int n);
        int i;
        for (i = 0; i < 400 && dones < n; i++)
            @(posedge clk);
        if (dones < n) begin
            failures++;
            finish_test;
        end
    endtask
    function automatic logic [31:0] sw(input logic [17:0] t);
        sw = {24'h000000, t[9:2]};
        sw[9] = !t[1];
        sw[10] = t[9:2] < t[17:10];
        sw[11] = t[0];
        sw[12] = t[17:10] > 8'h1c || t[9:2] < t[17:10];
        sw[8] = sw[9] | sw[10] | sw[11];
    endfunction
    function automatic logic [31:0] wd(input int f, k);
        int j;
        for (j = 0; j < 4; j++)
            wd[8*j +: 8] = u_card.bv(3'(f), 8'(4*k+j), ft[f][17:10]);
    endfunction
    ////////////////////////////////////////
    task automatic t_reset;
        rd_chk(9'h000, 32'h0, "ctrl");
        rd_chk(9'h004, 32'h0, "event");
        rd_chk(9'h008, 32'h0, "rxstat");
        rd_chk(9'h00c, 32'h0, "unmapped");
        kick;
        repeat (3) @(posedge clk);
        chk(32'(busy), 32'h0, "busy off");
    endtask
    task automatic t_eight;
        int f;
        logic ok;
        logic [17:0] t;
        wr_reg(9'h000, 32'h1);
        kick;
        for (f = 0; f < 8; f++) begin
            t = ft[f];
            u_card.send(3'(f), t[17:10], t[9:2], t[1], t[0], ok);
            chk(32'(ok), 32'h1, "armed");
            wait_dones(f + 1);
        end
        for (f = 0; f < 20 && sends < 1; f++)
            @(posedge clk);
        chk(sends, 32'h1, "await send");
        chk(32'(busy), 32'h0, "busy end");
        chk(dones, 32'h8, "done count");
        for (f = 0; f < 8; f++) begin
            t = ft[f];
            rd_chk(9'(256 + 32*f + 28), sw(t), "status");
            // Bytes between payload and status are never read
            if (t[17:10] <= 8'h1c)
                rd_chk(9'(256 + 32*f), wd(f, 0), "data");
        end
        rd_chk(9'h1b8, wd(5, 6), "tail");
        rd_chk(9'h008, 32'h8, "rxstat");
        rd_chk(9'h004, 32'h3, "event");
        wr_reg(9'h004, 32'h3);
        rd_chk(9'h004, 32'h0, "event clr");
    endtask
    task automatic t_idle;
        logic ok;
        kick;
        rd_chk(9'h008, 32'h10, "rxstat new");
        u_card.send(3'h1, 8'h04, 8'h04, 1'b1, 1'b0, ok);
        wait_dones(9);
        rd_chk(9'h008, 32'h11, "rxstat one");
        wr_reg(9'h000, 32'h5);
        rd_chk(9'h008, 32'h1, "rxstat idle");
        u_card.send(3'h2, 8'h04, 8'h04, 1'b1, 1'b0, ok);
        chk(32'(ok), 32'h0, "stopped");
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        rst_b = 1'b0;
        addr = 9'h000;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        start = 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_eight;
        t_idle;
        finish_test;
    end
endmodule
`default_nettype wire
